// ===== logic/srp_regs.svh
// Register offsets, field positions, reset values and header layout of the serial register port
`ifndef SRP_REGS_SVH
`define SRP_REGS_SVH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define SRP_OPTIONS_ADDR 5'h00
`define SRP_NUM_REGS 32
`define SRP_OPT_FOUR_WIRE_BIT 7
`define SRP_OPT_LSB_FIRST_BIT 6
`define SRP_OPT_RESET 8'h00
`define SRP_OPT_MASK 8'hC0

// ------------------------------------------------------------
// Header layout
// ------------------------------------------------------------
`define SRP_HDR_RW_BIT 7
`define SRP_HDR_CNT_HI 6
`define SRP_HDR_CNT_LO 5
`define SRP_HDR_ADDR_HI 4
`define SRP_HDR_BITS 4'h8
`define SRP_DATA_BITS 4'h8

// ------------------------------------------------------------
// Reset value sets chosen by the straps
// ------------------------------------------------------------
`define SRP_RST_HD_CFG0 8'h00
`define SRP_RST_HD_CFG1 8'h01
`define SRP_RST_FD_CFG0 8'h02
`define SRP_RST_FD_CFG1 8'h03

`endif

// ===== logic/srp_pkg.sv
// Types shared by the serial register port
package srp_pkg;
  typedef enum logic [1:0] {
    SRP_IDLE,
    SRP_HEADER,
    SRP_DATA,
    SRP_DONE
  } srp_state_e;
  typedef logic [7:0] srp_byte_t;
  typedef logic [4:0] srp_addr_t;
endpackage

// ===== logic/srp_serial_port.sv
// Serial register port: header decode, register file, read and write shifting
//
// Overview of operation
// [R1] Default link is clock, select, one data pin
// [R2] Select high keeps both data pins undriven
// [R3] Three-wire mode never drives the output pin
// [R4] Bit 7 of options routes reads to output
// [R5] Output pin drives only during read data
// [R6] Host opens each access with 8-bit header
// [R7] Header top bit: one reads, zero writes
// [R8] Next two header bits give byte count
// [R9] Count code is byte count minus one
// [R10] Low five header bits hold register address
// [R11] Data follows header with no gap
// [R12] Options bit 6 picks bit order, resets MSB-first
// [R13] MSB-first decrements address per further byte
// [R14] LSB-first reverses bits and increments address
// [R15] Header and write bits sampled on rising clock
// [R16] Host holds select low until last bit
// [R17] Read bits shift out on falling clock
// [R18] Four-wire read leaves data pin undriven
// [R19] Host writes zero into undefined bits
// [R20] Straps pick duplex mode and reset value set
`timescale 1ns/1ps
`include "srp_regs.svh"

module srp_serial_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Serial link pins
  input wire logic serial_clk,
  input wire logic port_select_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe_n,
  output logic serial_out_pin,
  output logic serial_out_oe_n,
  // Straps
  input wire logic duplex_strap,
  input wire logic config_strap,
  // Device-side view
  output logic four_wire_mode,
  output logic lsb_first_mode,
  output logic full_duplex_mode,
  output logic [7:0] scratch_reg0
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [1:0] sclk_sync_reg;
  logic [1:0] sel_sync_reg;
  logic [1:0] din_sync_reg;
  logic [1:0] mode_sync_reg;
  logic [1:0] cfg_sync_reg;
  logic sclk_prev_reg;

  // Two flops per pin before any logic reads it
  // Reset levels match the idle pins, so no false edge follows reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_sync_reg <= 2'h0;
      sel_sync_reg <= 2'h3;
      din_sync_reg <= 2'h0;
      mode_sync_reg <= 2'h0;
      cfg_sync_reg <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], serial_clk};
      sel_sync_reg <= {sel_sync_reg[0], port_select_n};
      din_sync_reg <= {din_sync_reg[0], serial_data_in};
      mode_sync_reg <= {mode_sync_reg[0], duplex_strap};
      cfg_sync_reg <= {cfg_sync_reg[0], config_strap};
    end
  end

  // Edge history of the synchronised serial clock
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_sync_reg[1];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic selected;
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg; // [R15]
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_prev_reg; // [R17]
  assign selected = ~sel_sync_reg[1];

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Reverses an 8-bit value for LSB-first order
  function automatic srp_pkg::srp_byte_t bit_rev(input srp_pkg::srp_byte_t v);
    srp_pkg::srp_byte_t r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  // Reset value chosen by the two straps
  function automatic srp_pkg::srp_byte_t strap_default(input logic fd, input logic cfg);
    srp_pkg::srp_byte_t r;
    r = 8'h00;
    case ({fd, cfg})
      2'b00: r = `SRP_RST_HD_CFG0;
      2'b01: r = `SRP_RST_HD_CFG1;
      2'b10: r = `SRP_RST_FD_CFG0;
      default: r = `SRP_RST_FD_CFG1;
    endcase
    return r;
  endfunction

  // ------------------------------------------------------------
  // Strap capture after reset release
  // ------------------------------------------------------------
  logic [1:0] strap_wait_reg;
  logic strap_load;
  logic full_duplex_reg;
  logic config_reg;

  // Waits for the strap synchronisers to fill, then loads once
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      strap_wait_reg <= 2'h0;
    end else if (strap_wait_reg != 2'h3) begin
      strap_wait_reg <= strap_wait_reg + 2'h1;
    end
  end
  assign strap_load = (strap_wait_reg == 2'h2);

  // Latches the straps once per reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      full_duplex_reg <= 1'b0;
      config_reg <= 1'b0;
    end else if (strap_load) begin
      full_duplex_reg <= mode_sync_reg[1]; // [R20]
      config_reg <= cfg_sync_reg[1]; // [R20]
    end
  end

  // ------------------------------------------------------------
  // Frame sequencer
  // ------------------------------------------------------------
  srp_pkg::srp_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [1:0] bytes_left_reg;
  srp_pkg::srp_byte_t shift_reg;
  srp_pkg::srp_addr_t addr_reg;
  logic read_reg;
  logic [7:0] options_reg;
  srp_pkg::srp_byte_t regs_mem [`SRP_NUM_REGS];

  logic lsb_mode;
  srp_pkg::srp_byte_t shift_next;
  srp_pkg::srp_byte_t hdr_word;
  srp_pkg::srp_byte_t wr_word;
  srp_pkg::srp_addr_t addr_step;
  srp_pkg::srp_addr_t hdr_addr;
  logic last_bit;

  assign lsb_mode = options_reg[`SRP_OPT_LSB_FIRST_BIT]; // [R12]
  assign shift_next = {shift_reg[6:0], din_sync_reg[1]};
  assign hdr_word = lsb_mode ? bit_rev(shift_next) : shift_next; // [R14]
  assign wr_word = lsb_mode ? bit_rev(shift_next) : shift_next; // [R14]
  assign hdr_addr = hdr_word[`SRP_HDR_ADDR_HI:0]; // [R10]
  assign addr_step = lsb_mode ? addr_reg + 5'h01 : addr_reg - 5'h01; // [R13] [R14]
  assign last_bit = (bit_cnt_reg == 4'h7);

  // Register read view, the options register taken from its own flops
  function automatic srp_pkg::srp_byte_t rd_value(input srp_pkg::srp_addr_t a,
                                                 input logic [7:0] opt,
                                                 input srp_pkg::srp_byte_t m);
    return (a == `SRP_OPTIONS_ADDR) ? opt : m;
  endfunction

  srp_pkg::srp_byte_t rd_word;
  srp_pkg::srp_byte_t rd_step_word;
  assign rd_word = rd_value(hdr_addr, options_reg, regs_mem[hdr_addr]);
  assign rd_step_word = rd_value(addr_step, options_reg, regs_mem[addr_step]);

  // State, counters and address of one framed access
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= srp_pkg::SRP_IDLE;
      bit_cnt_reg <= 4'h0;
      bytes_left_reg <= 2'h0;
      addr_reg <= 5'h00;
      read_reg <= 1'b0;
    end else if (!selected) begin
      state_reg <= srp_pkg::SRP_IDLE; // [R2]
      bit_cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        srp_pkg::SRP_IDLE: begin
          state_reg <= srp_pkg::SRP_HEADER; // [R6]
          bit_cnt_reg <= 4'h0;
        end
        srp_pkg::SRP_HEADER: begin
          if (sclk_rise) begin
            if (last_bit) begin
              state_reg <= srp_pkg::SRP_DATA; // [R11]
              bit_cnt_reg <= 4'h0;
              read_reg <= hdr_word[`SRP_HDR_RW_BIT]; // [R7]
              bytes_left_reg <= hdr_word[`SRP_HDR_CNT_HI:`SRP_HDR_CNT_LO]; // [R8] [R9]
              addr_reg <= hdr_addr;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        srp_pkg::SRP_DATA: begin
          if (sclk_rise) begin
            if (last_bit) begin
              bit_cnt_reg <= 4'h0;
              if (bytes_left_reg == 2'h0) begin
                state_reg <= srp_pkg::SRP_DONE; // [R16]
              end else begin
                bytes_left_reg <= bytes_left_reg - 2'h1;
                addr_reg <= addr_step; // [R13] [R14]
              end
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        srp_pkg::SRP_DONE: begin
          state_reg <= srp_pkg::SRP_DONE;
        end
        default: begin
          state_reg <= srp_pkg::SRP_IDLE;
        end
      endcase
    end
  end

  // Receive shifter, taking header bits and write data bits on each rising clock
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shift_reg <= 8'h00;
    end else if (!selected) begin
      shift_reg <= 8'h00;
    end else if (sclk_rise && state_reg == srp_pkg::SRP_HEADER) begin
      shift_reg <= shift_next; // [R15]
    end else if (sclk_rise && state_reg == srp_pkg::SRP_DATA && !read_reg) begin
      shift_reg <= shift_next; // [R15]
    end
  end

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic wr_commit;
  assign wr_commit = selected && sclk_rise && state_reg == srp_pkg::SRP_DATA
                     && !read_reg && last_bit;

  // Options register, reset to MSB-first three-wire
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      options_reg <= `SRP_OPT_RESET; // [R1] [R12]
    end else if (wr_commit && addr_reg == `SRP_OPTIONS_ADDR) begin
      options_reg <= wr_word & `SRP_OPT_MASK;
    end
  end

  // Remaining registers, reset to the strap-selected set
  generate
    for (genvar g = 1; g < `SRP_NUM_REGS; g++) begin : g_regs
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          regs_mem[g] <= 8'h00;
        end else if (strap_load) begin
          regs_mem[g] <= strap_default(mode_sync_reg[1], cfg_sync_reg[1]); // [R20]
        end else if (wr_commit && addr_reg == 5'(g)) begin
          regs_mem[g] <= wr_word;
        end
      end
    end
  endgenerate
  // Slot 0 is unused: the options register has its own flops
  assign regs_mem[0] = 8'h00;

  // ------------------------------------------------------------
  // Read transmitter
  // ------------------------------------------------------------
  srp_pkg::srp_byte_t tx_reg;
  logic tx_bit_reg;
  logic tx_active_reg;
  logic four_wire;
  assign four_wire = options_reg[`SRP_OPT_FOUR_WIRE_BIT]; // [R4]

  // Loads each read byte as the previous bit phase ends
  // A byte is loaded on a rising clock and emptied on the next eight falling
  // clocks, so load and shift never meet in one cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_reg <= 8'h00;
    end else if (selected && sclk_rise && state_reg == srp_pkg::SRP_HEADER && last_bit) begin
      tx_reg <= lsb_mode ? bit_rev(rd_word) : rd_word;
    end else if (selected && sclk_rise && state_reg == srp_pkg::SRP_DATA && last_bit
                 && read_reg && bytes_left_reg != 2'h0) begin
      tx_reg <= lsb_mode ? bit_rev(rd_step_word) : rd_step_word; // [R13] [R14]
    end else if (selected && sclk_fall && state_reg == srp_pkg::SRP_DATA && read_reg) begin
      // Shift as each bit is presented, so no bit is sent twice
      tx_reg <= {tx_reg[6:0], 1'b0}; // [R17]
    end
  end

  // Presents one bit per falling clock while reading
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_bit_reg <= 1'b0;
      tx_active_reg <= 1'b0;
    end else if (!selected) begin
      tx_active_reg <= 1'b0; // [R2]
    end else if (sclk_fall) begin
      tx_active_reg <= state_reg == srp_pkg::SRP_DATA && read_reg; // [R5] [R17]
      tx_bit_reg <= tx_reg[7]; // [R17]
    end
  end

  // ------------------------------------------------------------
  // Pin drivers, enables active low
  // ------------------------------------------------------------
  // Enables follow the synchronised select, so they release a few cycles late
  assign serial_data_out = tx_bit_reg;
  assign serial_out_pin = tx_bit_reg;
  assign serial_data_oe_n = ~(selected && tx_active_reg && !four_wire); // [R1] [R18]
  assign serial_out_oe_n = ~(selected && tx_active_reg && four_wire); // [R3] [R5]

  // Configuration seen by the rest of the device
  assign four_wire_mode = four_wire;
  assign lsb_first_mode = lsb_mode;
  assign full_duplex_mode = full_duplex_reg;
  assign scratch_reg0 = {7'h00, config_reg};

endmodule // srp_serial_port

// ===== test/srp_serial_port_asserts.sv
// Concurrent checks on the pins of the serial register port
`timescale 1ns/1ps
module srp_serial_port_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Link pins
  input wire logic serial_clk,
  input wire logic port_select_n,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_n,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe_n,
  // Straps and modes
  input wire logic duplex_strap,
  input wire logic config_strap,
  input wire logic four_wire_mode,
  input wire logic lsb_first_mode,
  input wire logic full_duplex_mode,
  input wire logic [7:0] scratch_reg0
);
  logic [3:0] up_cnt_reg;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Cycles since reset release, saturating
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      up_cnt_reg <= 4'h0;
    end else if (up_cnt_reg != 4'hF) begin
      up_cnt_reg <= up_cnt_reg + 4'h1;
    end
  end
  // Port idle, and serial clock high while a pin drives
  sequence sel_idle; port_select_n [*6]; endsequence
  sequence hold_out; (serial_clk && !serial_out_oe_n) [*6]; endsequence
  sequence hold_sdio; (serial_clk && !serial_data_oe_n) [*6]; endsequence
  AST_SEL_HIGH_HIZ: assert property (sel_idle |-> serial_data_oe_n && serial_out_oe_n)
    else $error("pin driven while port idle");
  AST_THREE_WIRE_OUT_OFF: assert property (!four_wire_mode [*2] |-> serial_out_oe_n)
    else $error("output pin driven in three-wire mode");
  AST_FOUR_WIRE_SDIO_OFF: assert property (four_wire_mode [*2] |-> serial_data_oe_n)
    else $error("data pin driven in four-wire mode");
  AST_DRIVE_START: assert property ($fell(serial_data_oe_n) || $fell(serial_out_oe_n)
    |-> !serial_clk && !port_select_n)
    else $error("drive began outside a falling phase of a frame");
  AST_OUT_STEADY: assert property (hold_out |-> $stable(serial_out_pin))
    else $error("output pin changed while serial clock high");
  AST_SDIO_STEADY: assert property (hold_sdio |-> $stable(serial_data_out))
    else $error("data pin changed while serial clock high");
  AST_STRAPS: assert property (up_cnt_reg > 4'h8
    |-> full_duplex_mode == duplex_strap && scratch_reg0 == {7'h00, config_strap})
    else $error("strap latch mismatch");
  AST_MODE_RESET: assert property ($rose(resetn) |-> !four_wire_mode && !lsb_first_mode)
    else $error("modes not cleared by reset");
endmodule // srp_serial_port_asserts

// ===== test/srp_host_model.sv
// Host controller model acting as serial port master
`timescale 1ns/1ps
module srp_host_model (
  // Clock
  input wire logic ref_clk,
  // Link pins
  output logic serial_clk,
  output logic port_select_n,
  output logic host_data,
  input wire logic sdio_level,
  input wire logic serial_out_pin
);
  // Idle link: clock still low, port deselected
  initial begin
    serial_clk = 1'b0;
    port_select_n = 1'b1;
    host_data = 1'b0;
  end
  // Half a serial clock period, 32 ns
  task automatic half();
    repeat (8) @(negedge ref_clk);
  endtask
  // One framed access: header, then count+1 bytes
  task automatic frame(input logic rw, input logic [1:0] cnt, input logic [4:0] addr,
      input logic lsb, input logic fw, input logic [31:0] wd, output logic [31:0] rd);
    logic [7:0] hdr;
    int k;
    int j;
    hdr = {rw, cnt, addr};
    rd = 32'h0;
    @(negedge ref_clk);
    port_select_n = 1'b0;
    half();
    for (int i = 0; i < 8 * (cnt + 2); i++) begin
      k = i / 8 - 1;
      j = lsb ? i % 8 : 7 - i % 8;
      if (i < 8) host_data = hdr[j];
      else if (!rw) host_data = wd[8 * k + j];
      else host_data = ~host_data; // Released line shows no stale value
      half();
      if (i >= 8 && rw) rd[8 * k + j] = fw ? serial_out_pin : sdio_level;
      serial_clk = 1'b1;
      half();
      serial_clk = 1'b0;
    end
    half();
    port_select_n = 1'b1;
    half();
  endtask
endmodule // srp_host_model

// ===== test/srp_serial_port_tb_top.sv
// Self-checking testbench of the serial register port
`timescale 1ns/1ps
module srp_serial_port_tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic duplex_strap = 1'b1;
  logic config_strap = 1'b1;
  logic serial_clk, port_select_n, host_data, sdio_level;
  logic serial_data_out, serial_data_oe_n, serial_out_pin, serial_out_oe_n;
  logic four_wire_mode, lsb_first_mode, full_duplex_mode;
  logic [7:0] scratch_reg0;
  logic [31:0] rd;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;
  // Level of the shared data pin
  assign sdio_level = serial_data_oe_n ? host_data : serial_data_out;
  // Separate output pin as the host sees it, inverted while released
  logic out_level;
  assign out_level = serial_out_oe_n ? ~serial_out_pin : serial_out_pin;
  srp_serial_port dut_u (.ref_clk, .resetn, .serial_clk, .port_select_n,
    .serial_data_in(sdio_level), .serial_data_out, .serial_data_oe_n, .serial_out_pin,
    .serial_out_oe_n, .duplex_strap, .config_strap, .four_wire_mode, .lsb_first_mode,
    .full_duplex_mode, .scratch_reg0);
  srp_host_model host_u (.ref_clk, .serial_clk, .port_select_n, .host_data, .sdio_level,
    .serial_out_pin(out_level));
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("modes", 32'h0, {four_wire_mode, lsb_first_mode});
    chk("pins idle", 32'h3, {serial_data_oe_n, serial_out_oe_n});
    chk("duplex", 32'h1, full_duplex_mode);
    chk("scratch", 32'h1, scratch_reg0);
    host_u.frame(1'b1, 2'h0, 5'h05, 1'b0, 1'b0, 32'h0, rd);
    chk("strap set", 32'h03, rd);
  endtask
  task automatic t_msb();
    host_u.frame(1'b0, 2'h3, 5'h07, 1'b0, 1'b0, 32'h44332211, rd);
    host_u.frame(1'b1, 2'h3, 5'h07, 1'b0, 1'b0, 32'h0, rd);
    chk("msb burst", 32'h44332211, rd);
    host_u.frame(1'b1, 2'h0, 5'h05, 1'b0, 1'b0, 32'h0, rd);
    chk("msb single", 32'h33, rd);
  endtask
  task automatic t_four();
    host_u.frame(1'b0, 2'h0, 5'h00, 1'b0, 1'b0, 32'h80, rd);
    chk("four wire", 32'h1, four_wire_mode);
    host_u.frame(1'b1, 2'h1, 5'h06, 1'b0, 1'b1, 32'h0, rd);
    chk("four wire read", 32'h3322, rd);
    host_u.frame(1'b1, 2'h0, 5'h00, 1'b0, 1'b1, 32'h0, rd);
    chk("options", 32'h80, rd);
  endtask
  // Reset in mid-run with the duplex strap changed
  task automatic t_rerst();
    @(negedge ref_clk);
    resetn = 1'b0;
    duplex_strap = 1'b0;
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    chk("modes after reset", 32'h0, {four_wire_mode, lsb_first_mode});
    repeat (20) @(negedge ref_clk);
    chk("duplex half", 32'h0, full_duplex_mode);
    host_u.frame(1'b1, 2'h0, 5'h06, 1'b0, 1'b0, 32'h0, rd);
    chk("half duplex set", 32'h01, rd);
  endtask
  task automatic t_lsb();
    host_u.frame(1'b0, 2'h0, 5'h00, 1'b0, 1'b1, 32'hC0, rd);
    chk("lsb mode", 32'h1, lsb_first_mode);
    host_u.frame(1'b0, 2'h2, 5'h0A, 1'b1, 1'b1, 32'h00C3B2A1, rd);
    host_u.frame(1'b1, 2'h2, 5'h0A, 1'b1, 1'b1, 32'h0, rd);
    chk("lsb burst", 32'h00C3B2A1, rd);
    host_u.frame(1'b0, 2'h0, 5'h00, 1'b1, 1'b1, 32'h00, rd);
    host_u.frame(1'b1, 2'h0, 5'h0B, 1'b0, 1'b0, 32'h0, rd);
    chk("back to three wire", 32'hB2, rd);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (20) @(negedge ref_clk);
    t_reset();
    t_msb();
    t_four();
    t_rerst();
    t_lsb();
    finish_test();
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
endmodule // srp_serial_port_tb_top
bind srp_serial_port srp_serial_port_asserts chk_u (.ref_clk, .resetn, .serial_clk,
  .port_select_n, .serial_data_in, .serial_data_out, .serial_data_oe_n, .serial_out_pin,
  .serial_out_oe_n, .duplex_strap, .config_strap, .four_wire_mode, .lsb_first_mode,
  .full_duplex_mode, .scratch_reg0);
